// >>> verilog/mts_regs.svh
`ifndef MTS_REGS_SVH
`define MTS_REGS_SVH

// Register word indices
`define MTS_A_CTRL      3'h0
`define MTS_A_COUNT     3'h1
`define MTS_A_DELAY     3'h2
`define MTS_A_STAT      3'h3
`define MTS_A_DISP      3'h4
`define MTS_A_CMD       3'h5

// Control and command field positions
`define MTS_F_SRC_LO    0
`define MTS_F_SRC_HI    1
`define MTS_F_TOUT      2
`define MTS_F_HOLD      3
`define MTS_F_REMOTE    4
`define MTS_F_TOL_LO    5
`define MTS_F_TOL_HI    6
`define MTS_F_DAUTO     7
`define MTS_F_CMD_RST   0

// Reset values
`define MTS_RST_SRC     2'h0
`define MTS_RST_TOL     2'h1
`define MTS_RST_COUNT   16'h0001
`define MTS_RST_DLY_MS  22'h000000

// Limits
`define MTS_CNT_MAX     16'hC350
`define MTS_DLY_MAX_S   32'h00000E10
`define MTS_MS_PER_S    32'h000003E8

// Timing
`define MTS_CLK_NS      32'h00000064
`define MTS_MS_NS       32'h000F4240
`define MTS_COMP_NS     32'h000001F4

// Hold band: half band of tol/10000 on either side
`define MTS_TOL_DIV     16'h4E20
`define MTS_TOL_K0      10'h001
`define MTS_TOL_K1      10'h00A
`define MTS_TOL_K2      10'h064
`define MTS_TOL_K3      10'h3E8

`endif

// >>> verilog/mts_pkg.sv
`default_nettype none
package mts_pkg;

    typedef enum logic [1:0] {
        src_auto   = 2'h0,
        src_single = 2'h1,
        src_ext    = 2'h2
    } mts_src_t;

    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_dly  = 2'h1,
        st_meas = 2'h2
    } mts_state_t;

    typedef struct packed {
        logic [2:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mts_bus_req_t;

    typedef struct packed {
        logic               done;
        logic signed [23:0] value;
    } mts_rdg_t;

    typedef struct packed {
        logic [1:0]         src;
        logic               tout_en;
        logic               hold_en;
        logic               remote;
        logic [1:0]         tol;
        logic               dly_auto;
        logic [15:0]        count;
        logic [21:0]        dly_ms;
        mts_state_t         state;
        logic [15:0]        left;
        logic [13:0]        ms_cnt;
        logic [21:0]        dly_left;
        logic               start;
        logic               sampling;
        logic               comp_b;
        logic [3:0]         comp_cnt;
        logic               ext_s1;
        logic               ext_s2;
        logic               ext_p;
        logic               key_s1;
        logic               key_s2;
        logic               key_p;
        logic [1:0]         hist_n;
        logic signed [23:0] r1;
        logic signed [23:0] r2;
        logic signed [23:0] disp;
        logic               stable;
        logic [31:0]        rdata;
    } mts_st_t;

endpackage
`default_nettype wire

// >>> verilog/mts_seq.sv
// Contract
// - Trigger source is auto, single key press, or external input.
// - Each accepted trigger takes one reading or a programmed count.
// - Trigger source returns to auto at power-up and remote reset.
// - Auto source retriggers back to back at full rate.
// - Single source: each key press starts one burst; the code ignores presses made while a burst is running.
// - External source: each low pulse on input starts one burst; the code ignores pulses that arrive while a burst is running.
// - Sampling indicator lit during every single measurement.
// - Single key press in remote mode returns to local operation.
// - Hold filter active only locally, ignored in remote mode.
// - Stable means three consecutive readings within tolerance band.
// - Tolerance 0.01, 0.1, 1 or 10 percent; default 0.1 percent.
// - Display kept if new stable reading within band of shown value.
// - Count 1 to 50000, default 1, restored by remote reset.
// - Programmed delay precedes every reading of a burst.
// - Manual delay up to 3600 s; resets to automatic delay.
// - Manual delay applies equally in every function and range.
// - Completion pulse low after each measurement only when enabled.
// - Completion output and external input form a handshake.
`default_nettype none
`include "mts_regs.svh"

module mts_seq #(
    parameter int unsigned CYC_PER_MS  = `MTS_MS_NS / `MTS_CLK_NS,
    parameter logic [21:0] AUTO_DLY_MS = 22'h000000
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire mts_pkg::mts_bus_req_t bus_req,
    output var  logic [31:0]          bus_rdata,
    input  wire logic                 ext_trig_b,
    input  wire logic                 single_key,
    input  wire mts_pkg::mts_rdg_t    rdg,
    output var  logic                 meas_start,
    output var  logic                 sampling_led,
    output var  logic                 measurement_complete_output_b,
    output var  logic                 remote_mode,
    output var  logic                 hold_stable,
    output var  logic signed [23:0]   display_value
);

    localparam logic [3:0] COMP_CYC =
        4'((`MTS_COMP_NS + `MTS_CLK_NS - 1) / `MTS_CLK_NS);
    localparam logic [21:0] DLY_MAX =
        22'(`MTS_DLY_MAX_S * `MTS_MS_PER_S);
    localparam logic [13:0] MS_LAST = 14'(CYC_PER_MS - 1);

    localparam mts_pkg::mts_st_t ST_RST = '{
        src:      `MTS_RST_SRC,
        tol:      `MTS_RST_TOL,
        dly_auto: 1'b1,
        count:    `MTS_RST_COUNT,
        dly_ms:   `MTS_RST_DLY_MS,
        state:    mts_pkg::st_idle,
        comp_b:   1'b1,
        ext_s1:   1'b1,
        ext_s2:   1'b1,
        ext_p:    1'b1,
        default:  '0
    };

    mts_pkg::mts_st_t s_r;
    mts_pkg::mts_st_t s_nxt;
    logic             ext_fall;
    logic             key_rise;
    logic             trig;
    logic             ctrl_wr;
    logic             cmd_rst;
    logic             stable3;

    // Half-band test against the reference magnitude
    function automatic logic in_band(
        input logic signed [23:0] ref_v,
        input logic signed [23:0] new_v,
        input logic [1:0]         tol
    );
        logic signed [24:0] d;
        logic [24:0]        ad;
        logic [24:0]        ar;
        logic [9:0]         k;
        logic [47:0]        lhs;
        logic [47:0]        rhs;
        d   = 25'(ref_v) - 25'(new_v);
        ad  = d[24] ? 25'(-d) : 25'(d);
        ar  = ref_v[23] ? 25'(-26'(ref_v)) : 25'(ref_v);
        case (tol)
            2'h0:    k = `MTS_TOL_K0;
            2'h1:    k = `MTS_TOL_K1;
            2'h2:    k = `MTS_TOL_K2;
            default: k = `MTS_TOL_K3;
        endcase
        lhs = 48'(ad) * 48'(`MTS_TOL_DIV);
        rhs = 48'(ar) * 48'(k);
        return lhs <= rhs;
    endfunction

    // Only the second stage and its delayed copy feed edge logic
    assign ext_fall = s_r.ext_p & ~s_r.ext_s2;
    assign key_rise = s_r.key_s2 & ~s_r.key_p;
    assign ctrl_wr  = bus_req.wr && bus_req.addr == `MTS_A_CTRL;
    assign cmd_rst  = bus_req.wr && bus_req.addr == `MTS_A_CMD
                      && bus_req.wdata[`MTS_F_CMD_RST];
    assign stable3  = s_r.hist_n == 2'h2
                      && in_band(rdg.value, s_r.r1, s_r.tol)
                      && in_band(rdg.value, s_r.r2, s_r.tol);

    always_comb begin
        case (mts_pkg::mts_src_t'(s_r.src))
            mts_pkg::src_auto:   trig = 1'b1;
            mts_pkg::src_single: trig = key_rise;
            mts_pkg::src_ext:    trig = ext_fall;
            default:             trig = 1'b0;
        endcase
    end

    always_comb begin
        s_nxt          = s_r;
        s_nxt.start    = 1'b0;
        s_nxt.rdata    = 32'h00000000;
        s_nxt.ext_s1   = ext_trig_b;
        s_nxt.ext_s2   = s_r.ext_s1;
        s_nxt.ext_p    = s_r.ext_s2;
        s_nxt.key_s1   = single_key;
        s_nxt.key_s2   = s_r.key_s1;
        s_nxt.key_p    = s_r.key_s2;

        if (key_rise) begin
            s_nxt.remote = 1'b0;
        end

        if (bus_req.wr) begin
            case (bus_req.addr)
                `MTS_A_CTRL: begin
                    s_nxt.src      = bus_req.wdata[`MTS_F_SRC_HI:
                                                   `MTS_F_SRC_LO];
                    s_nxt.tout_en  = bus_req.wdata[`MTS_F_TOUT];
                    s_nxt.hold_en  = bus_req.wdata[`MTS_F_HOLD];
                    s_nxt.remote   = bus_req.wdata[`MTS_F_REMOTE];
                    s_nxt.tol      = bus_req.wdata[`MTS_F_TOL_HI:
                                                   `MTS_F_TOL_LO];
                    s_nxt.dly_auto = bus_req.wdata[`MTS_F_DAUTO];
                end
                `MTS_A_COUNT: begin
                    if (bus_req.wdata[15:0] == 16'h0000) begin
                        s_nxt.count = 16'h0001;
                    end else if (bus_req.wdata[31:16] != 16'h0000
                                 || bus_req.wdata[15:0]
                                    > `MTS_CNT_MAX) begin
                        s_nxt.count = `MTS_CNT_MAX;
                    end else begin
                        s_nxt.count = bus_req.wdata[15:0];
                    end
                end
                `MTS_A_DELAY: begin
                    // Manual delay capped at 3600 s
                    if (bus_req.wdata[31:22] != 10'h000
                        || bus_req.wdata[21:0] > DLY_MAX) begin
                        s_nxt.dly_ms = DLY_MAX;
                    end else begin
                        s_nxt.dly_ms = bus_req.wdata[21:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (cmd_rst) begin
            s_nxt.src      = `MTS_RST_SRC;
            s_nxt.tol      = `MTS_RST_TOL;
            s_nxt.count    = `MTS_RST_COUNT;
            s_nxt.dly_ms   = `MTS_RST_DLY_MS;
            s_nxt.dly_auto = 1'b1;
        end

        if (bus_req.rd) begin
            case (bus_req.addr)
                `MTS_A_CTRL: s_nxt.rdata = {24'h000000, s_r.dly_auto,
                    s_r.tol, s_r.remote, s_r.hold_en, s_r.tout_en,
                    s_r.src};
                `MTS_A_COUNT: s_nxt.rdata = {16'h0000, s_r.count};
                `MTS_A_DELAY: s_nxt.rdata = {10'h000, s_r.dly_ms};
                `MTS_A_STAT: s_nxt.rdata = {10'h000, s_r.state,
                    s_r.stable, s_r.sampling, s_r.comp_b,
                    s_r.state != mts_pkg::st_idle, s_r.left};
                `MTS_A_DISP: s_nxt.rdata = 32'(s_r.disp);
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end

        // Pulse low for a fixed count
        if (!s_r.comp_b) begin
            if (s_r.comp_cnt == 4'h0) begin
                s_nxt.comp_b = 1'b1;
            end else begin
                s_nxt.comp_cnt = s_r.comp_cnt - 4'h1;
            end
        end

        case (s_r.state)
            mts_pkg::st_idle: begin
                if (trig) begin
                    s_nxt.left     = s_r.count;
                    s_nxt.dly_left = s_r.dly_auto ? AUTO_DLY_MS
                                                  : s_r.dly_ms;
                    s_nxt.ms_cnt   = 14'h0000;
                    s_nxt.state    = mts_pkg::st_dly;
                end
            end
            mts_pkg::st_dly: begin
                if (s_r.dly_left == 22'h000000) begin
                    s_nxt.start    = 1'b1;
                    s_nxt.sampling = 1'b1;
                    s_nxt.state    = mts_pkg::st_meas;
                end else if (s_r.ms_cnt == MS_LAST) begin
                    s_nxt.ms_cnt   = 14'h0000;
                    s_nxt.dly_left = s_r.dly_left - 22'h000001;
                end else begin
                    s_nxt.ms_cnt   = s_r.ms_cnt + 14'h0001;
                end
            end
            mts_pkg::st_meas: begin
                if (rdg.done) begin
                    s_nxt.sampling = 1'b0;
                    if (s_r.tout_en) begin
                        s_nxt.comp_b   = 1'b0;
                        s_nxt.comp_cnt = COMP_CYC - 4'h1;
                    end
                    if (s_r.left <= 16'h0001) begin
                        s_nxt.left  = 16'h0000;
                        s_nxt.state = mts_pkg::st_idle;
                    end else begin
                        s_nxt.left     = s_r.left - 16'h0001;
                        s_nxt.dly_left = s_r.dly_auto ? AUTO_DLY_MS
                                                      : s_r.dly_ms;
                        s_nxt.ms_cnt   = 14'h0000;
                        s_nxt.state    = mts_pkg::st_dly;
                    end
                end
            end
            default: begin
                s_nxt.state = mts_pkg::st_idle;
            end
        endcase

        if (rdg.done && s_r.state == mts_pkg::st_meas) begin
            s_nxt.r1     = rdg.value;
            s_nxt.r2     = s_r.r1;
            if (s_r.hist_n != 2'h2) begin
                s_nxt.hist_n = s_r.hist_n + 2'h1;
            end
            s_nxt.stable = stable3;
            if (!s_r.hold_en || s_r.remote) begin
                s_nxt.disp = rdg.value;
            end else if (stable3
                         && !in_band(s_r.disp, rdg.value, s_r.tol)) begin
                s_nxt.disp = rdg.value;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus_rdata                     = s_r.rdata;
    assign meas_start                    = s_r.start;
    assign sampling_led                  = s_r.sampling;
    assign measurement_complete_output_b = s_r.comp_b;
    assign remote_mode                   = s_r.remote;
    assign hold_stable                   = s_r.stable;
    assign display_value                 = s_r.disp;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_ext_burst_start: assert property (
        s_r.state == mts_pkg::st_idle && s_r.src == mts_pkg::src_ext
        && ext_fall && !bus_req.wr
        |=> s_r.state == mts_pkg::st_dly && s_r.left == $past(s_r.count))
        else $error("External edge did not start a burst");

    a_busy_ignore: assert property (
        s_r.state == mts_pkg::st_dly && ext_fall
        |=> s_r.left == $past(s_r.left))
        else $error("Trigger accepted during a burst");

    a_auto_retrig: assert property (
        s_r.state == mts_pkg::st_idle && s_r.src == mts_pkg::src_auto
        && !bus_req.wr |=> s_r.state == mts_pkg::st_dly)
        else $error("Auto source did not retrigger");

    a_single_press: assert property (
        s_r.state == mts_pkg::st_idle && s_r.src == mts_pkg::src_single
        && !key_rise && !bus_req.wr |=> s_r.state == mts_pkg::st_idle)
        else $error("Single source ran without a key press");

    a_sampling_meas: assert property (
        s_r.sampling == (s_r.state == mts_pkg::st_meas))
        else $error("Sampling indicator out of step");

    a_remote_local: assert property (
        key_rise && s_r.remote && !ctrl_wr |=> !s_r.remote)
        else $error("Key press did not return to local");

    a_hold_remote: assert property (
        s_r.state == mts_pkg::st_meas && rdg.done && s_r.remote
        |=> s_r.disp == $past(rdg.value))
        else $error("Hold filter acted in remote mode");

    a_count_range: assert property (
        s_r.count != 16'h0000 && s_r.count <= `MTS_CNT_MAX)
        else $error("Reading count out of range");

    a_cmd_restore: assert property (
        cmd_rst |=> s_r.src == `MTS_RST_SRC && s_r.count == `MTS_RST_COUNT)
        else $error("Remote reset did not restore settings");

    a_delay_each: assert property (
        s_r.state == mts_pkg::st_meas && rdg.done && s_r.left > 16'h0001
        |=> s_r.state == mts_pkg::st_dly)
        else $error("Reading taken without delay");

    a_comp_fire: assert property (
        s_r.state == mts_pkg::st_meas && rdg.done && s_r.tout_en
        |=> !measurement_complete_output_b)
        else $error("Completion pulse missing");

    a_comp_gated: assert property (
        s_r.comp_b && !s_r.tout_en |=> s_r.comp_b)
        else $error("Completion pulse while disabled");

    a_comp_width: assert property (
        $fell(s_r.comp_b) && COMP_CYC == 4'h5
        |-> !s_r.comp_b [*5] ##1 s_r.comp_b)
        else $error("Completion pulse width wrong");

    c_ext_burst: cover property (
        s_r.src == mts_pkg::src_ext && ext_fall
        && s_r.state == mts_pkg::st_idle);
    c_comp_pulse: cover property ($fell(s_r.comp_b));
    c_hold_keep: cover property (
        rdg.done && stable3 && s_r.hold_en && !s_r.remote
        && s_r.state == mts_pkg::st_meas
        && in_band(s_r.disp, rdg.value, s_r.tol));
    c_multi_burst: cover property (
        s_r.state == mts_pkg::st_meas && rdg.done && s_r.left > 16'h0002);

endmodule
`default_nettype wire

// >>> tb/mts_switch_model.sv
`default_nettype none
// Switch device on the far side of the trigger handshake
module mts_switch_model (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       measurement_complete_output_b,
    input  wire logic       go,
    input  wire logic [7:0] steps,
    output var  logic       ext_trig_b
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] left_r;
    logic [2:0] cnt_r;
    logic       comp_q;
    logic       kick;

    // Advance then trigger
    // Low pulse lasts three cycles so the two-flop sync cannot miss it
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            left_r     <= 8'h00;
            cnt_r      <= 3'h0;
            comp_q     <= 1'b1;
            ext_trig_b <= 1'b1;
        end else begin
            kick = go || (measurement_complete_output_b && !comp_q
                          && left_r > 8'h01);
            comp_q <= measurement_complete_output_b;
            if (go) begin
                left_r <= steps;
            end else if (kick) begin
                left_r <= left_r - 8'h01;
            end
            if (kick) begin
                cnt_r <= 3'h5;
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end
            ext_trig_b <= !(cnt_r >= 3'h1 && cnt_r <= 3'h3);
        end
    end
endmodule
`default_nettype wire

// >>> tb/measurement_trigger_sequencer_tb.sv
`default_nettype none
`include "mts_regs.svh"
module measurement_trigger_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // Short ms so delayed bursts stay cheap to simulate
    localparam int unsigned CPM = 4;

    logic                  mclk;
    logic                  rst_b;
    mts_pkg::mts_bus_req_t bus_req;
    logic [31:0]           bus_rdata;
    logic                  ext_trig_b;
    logic                  single_key;
    mts_pkg::mts_rdg_t     rdg;
    logic                  meas_start;
    logic                  sampling_led;
    logic                  comp_b;
    logic                  remote_mode;
    logic                  hold_stable;
    logic signed [23:0]    display_value;
    logic signed [23:0]    eng_val;
    logic                  go;
    logic [7:0]            steps;
    logic [2:0]            eng_cnt;
    logic [31:0]           d;
    int                    err_count;
    int                    samples_checked;
    int                    n_start;
    int                    n_comp;
    int                    gap;
    int                    min_gap;
    int                    low_w;
    int                    last_w;

    mts_seq #(.CYC_PER_MS(CPM)) mts_seq_i (
        .mclk                          (mclk),
        .rst_b                         (rst_b),
        .bus_req                       (bus_req),
        .bus_rdata                     (bus_rdata),
        .ext_trig_b                    (ext_trig_b),
        .single_key                    (single_key),
        .rdg                           (rdg),
        .meas_start                    (meas_start),
        .sampling_led                  (sampling_led),
        .measurement_complete_output_b (comp_b),
        .remote_mode                   (remote_mode),
        .hold_stable                   (hold_stable),
        .display_value                 (display_value)
    );

    mts_switch_model mts_switch_model_i (
        .mclk                          (mclk),
        .rst_b                         (rst_b),
        .measurement_complete_output_b (comp_b),
        .go                            (go),
        .steps                         (steps),
        .ext_trig_b                    (ext_trig_b)
    );

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Engine answers three cycles after each start
    always @(posedge mclk) begin
        rdg.done  <= 1'b0;
        rdg.value <= eng_val;
        gap = gap + 1;
        if (meas_start === 1'b1) begin
            n_start++;
            if (gap < min_gap) min_gap = gap;
            eng_cnt <= 3'h3;
        end else if (eng_cnt != 3'h0) begin
            eng_cnt <= eng_cnt - 3'h1;
            if (eng_cnt == 3'h1) rdg.done <= 1'b1;
        end
        if (rdg.done === 1'b1) begin
            gap = 0;
            check("sampling_led", {31'h0, sampling_led}, 32'h1);
        end
        if (comp_b === 1'b0) begin
            low_w++;
        end else if (low_w != 0) begin
            last_w = low_w;
            low_w  = 0;
            n_comp++;
        end
    end

    function automatic logic [31:0] ctrl(input logic [1:0] s,
        input logic t, input logic h, input logic r, input logic [1:0] tl);
        return {24'h000000, 1'b0, tl, r, h, t, s};
    endfunction

    task automatic bw(input logic [2:0] a, input logic [31:0] wd);
        bus_req.addr  <= a;
        bus_req.wdata <= wd;
        bus_req.wr    <= 1'b1;
        @(posedge mclk);
        bus_req.wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic br(input logic [2:0] a, output logic [31:0] rd);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 rd = bus_rdata;
        @(posedge mclk);
    endtask

    task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
        logic [31:0] v;
        br(a, v);
        check("register", v, exp);
    endtask

    task automatic wait_idle();
        logic [31:0] v;
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 400; i++) begin
            br(`MTS_A_STAT, v);
            if (v[16] == 1'b0) break;
        end
        // Last completion pulse outlives the busy flag
        repeat (8) @(posedge mclk);
    endtask

    task automatic press();
        single_key <= 1'b1;
        repeat (4) @(posedge mclk);
        single_key <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic kick(input logic [7:0] n);
        steps <= n;
        go    <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic t_reset();
        rchk(`MTS_A_CTRL, 32'h000000A0);
        rchk(`MTS_A_COUNT, 32'h00000001);
        rchk(`MTS_A_DELAY, 32'h00000000);
        rchk(3'h6, 32'h00000000);
        check("remote_mode", {31'h0, remote_mode}, 32'h0);
    endtask

    task automatic t_limits();
        // Single source so the clamp values never start a burst
        bw(`MTS_A_CTRL, ctrl(2'h1, 1'b0, 1'b0, 1'b0, 2'h1));
        wait_idle();
        bw(`MTS_A_COUNT, 32'h00000000);
        rchk(`MTS_A_COUNT, 32'h00000001);
        bw(`MTS_A_COUNT, 32'h0000C351);
        rchk(`MTS_A_COUNT, 32'h0000C350);
        bw(`MTS_A_DELAY, 32'h0036EE81);
        rchk(`MTS_A_DELAY, 32'h0036EE80);
        bw(`MTS_A_COUNT, 32'h00000001);
        bw(`MTS_A_DELAY, 32'h00000000);
        for (int t = 0; t < 4; t++) begin
            bw(`MTS_A_CTRL, ctrl(2'h1, 1'b0, 1'b0, 1'b0, t[1:0]));
            rchk(`MTS_A_CTRL, ctrl(2'h1, 1'b0, 1'b0, 1'b0, t[1:0]));
        end
        bw(`MTS_A_CTRL, ctrl(2'h0, 1'b0, 1'b0, 1'b0, 2'h1));
    endtask

    task automatic t_auto();
        n_start = 0;
        n_comp  = 0;
        repeat (70) @(posedge mclk);
        check("auto rate", {31'h0, n_start >= 6}, 32'h1);
        check("no pulse", n_comp, 32'h0);
    endtask

    task automatic t_delay();
        bw(`MTS_A_CTRL, ctrl(2'h1, 1'b1, 1'b0, 1'b0, 2'h1));
        wait_idle();
        bw(`MTS_A_COUNT, 32'h00000003);
        bw(`MTS_A_DELAY, 32'h00000002);
        n_start = 0;
        n_comp  = 0;
        min_gap = 1000;
        press();
        wait_idle();
        check("burst starts", n_start, 32'h3);
        check("burst pulses", n_comp, 32'h3);
        check("pulse width", last_w, 32'h5);
        check("gap low", {31'h0, min_gap >= 2 * CPM}, 32'h1);
        check("gap high", {31'h0, min_gap <= 2 * CPM + 4}, 32'h1);
    endtask

    task automatic t_ext();
        bw(`MTS_A_CTRL, ctrl(2'h2, 1'b1, 1'b0, 1'b0, 2'h1));
        bw(`MTS_A_COUNT, 32'h00000001);
        bw(`MTS_A_DELAY, 32'h00000000);
        n_start = 0;
        n_comp  = 0;
        kick(8'h04);
        for (int i = 0; i < 400 && n_comp < 4; i++) @(posedge mclk);
        // Extra cycles show that nothing further is triggered
        repeat (40) @(posedge mclk);
        check("handshake starts", n_start, 32'h4);
        check("handshake pulses", n_comp, 32'h4);
        bw(`MTS_A_COUNT, 32'h00000003);
        bw(`MTS_A_DELAY, 32'h00000002);
        n_start = 0;
        kick(8'h01);
        repeat (12) @(posedge mclk);
        kick(8'h01);
        wait_idle();
        repeat (20) @(posedge mclk);
        check("busy trigger", n_start, 32'h3);
        bw(`MTS_A_DELAY, 32'h00000000);
    endtask

    task automatic burst(input logic [23:0] v, input logic [31:0] exp,
                         input logic st);
        eng_val = v;
        press();
        wait_idle();
        check("display", display_value, exp);
        check("hold_stable", {31'h0, hold_stable}, {31'h0, st});
    endtask

    task automatic t_hold();
        bw(`MTS_A_CTRL, ctrl(2'h1, 1'b0, 1'b1, 1'b0, 2'h2));
        bw(`MTS_A_COUNT, 32'h00000003);
        burst(24'h001388, 32'h00001388, 1'b1);
        burst(24'h00139C, 32'h00001388, 1'b1);
        burst(24'h001770, 32'h00001770, 1'b1);
        bw(`MTS_A_COUNT, 32'h00000002);
        burst(24'h001F40, 32'h00001770, 1'b0);
        bw(`MTS_A_COUNT, 32'h00000001);
        burst(24'h001F40, 32'h00001F40, 1'b1);
    endtask

    task automatic t_remote();
        bw(`MTS_A_CTRL, ctrl(2'h0, 1'b0, 1'b1, 1'b1, 2'h2));
        check("remote set", {31'h0, remote_mode}, 32'h1);
        eng_val = 24'h000064;
        for (int i = 0; i < 50 && rdg.done !== 1'b1; i++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        check("remote display", display_value, 32'h00000064);
        bw(`MTS_A_CTRL, ctrl(2'h1, 1'b0, 1'b0, 1'b1, 2'h2));
        wait_idle();
        press();
        check("local again", {31'h0, remote_mode}, 32'h0);
        wait_idle();
        bw(`MTS_A_COUNT, 32'h00000005);
        bw(`MTS_A_DELAY, 32'h00000007);
        bw(`MTS_A_CMD, 32'h00000001);
        br(`MTS_A_CTRL, d);
        check("ctrl restore", d & 32'h000000E3, 32'h000000A0);
        rchk(`MTS_A_COUNT, 32'h00000001);
        rchk(`MTS_A_DELAY, 32'h00000000);
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        repeat (30000) @(posedge mclk);
        err_count++;
        print_verdict();
    end

    initial begin
        bus_req         = '0;
        single_key      = 1'b0;
        rdg             = '0;
        eng_val         = '0;
        eng_cnt         = 3'h0;
        go              = 1'b0;
        steps           = 8'h00;
        err_count       = 0;
        samples_checked = 0;
        n_start         = 0;
        n_comp          = 0;
        gap             = 0;
        min_gap         = 1000;
        low_w           = 0;
        last_w          = 0;
        rst_b           = 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_limits();
        t_auto();
        t_delay();
        t_ext();
        t_hold();
        t_remote();
        print_verdict();
    end
endmodule
`default_nettype wire
